// File: src/tio_pkg.sv
// Constants for the timer pin function select block.
// Assumes a classic Wishbone slave with 32-bit data, one register per aligned word.
// Summary of operation
// - Low nibble of each control register selects the A (or C) register function
// - Channel 0 register C has its own selector in the low nibble of the CD control register
// - Output code x01 drives the pin low on compare match
// - Output code x10 drives the pin high on compare match
// - Output code x11 toggles the pin on compare match
// - Bit 2 picks initial level; codes 0000 and 0100 disable the output
// - Capture code 1x00 copies the counter on a rising pin edge
// - Capture code 1x01 copies the counter on a falling pin edge
// - Capture code 1x1x copies the counter on both pin edges
// - With buffer enable set, register C makes no capture or compare events
// - The initial level reaches the pin while the counter is stopped, and on each counter clear in PWM mode 2
// - In PWM mode 2 the level is driven when the counter clears
// - Reset clears every control register to zero, outputs disabled
package tio_pkg;
    localparam int          NUM_PINS     = 8;
    localparam int          SEL_W        = 4;
    localparam logic [7:0]  ADR_CH0_AB   = 8'h00;
    localparam logic [7:0]  ADR_CH0_CD   = 8'h04;
    localparam logic [7:0]  ADR_CH1      = 8'h08;
    localparam logic [7:0]  ADR_CH2      = 8'h0c;
    localparam logic [7:0]  ADR_CTRL     = 8'h10;
    localparam logic [7:0]  ADR_PINS     = 8'h14;
    localparam int          CTRL_START0  = 0;
    localparam int          CTRL_START1  = 1;
    localparam int          CTRL_START2  = 2;
    localparam int          CTRL_BUF_AC  = 3;
    localparam int          CTRL_PWM2_0  = 4;
    localparam int          CTRL_PWM2_1  = 5;
    localparam int          CTRL_PWM2_2  = 6;
    localparam logic [7:0]  IOCTRL_RST   = 8'h00;
    localparam logic [6:0]  CTRL_RST     = 7'h00;
    localparam int          SEL_HI_B     = 4;
    localparam int          SEL_LO_B     = 0;
endpackage

// File: src/tio_func_select.sv
// Pin function select for a three-channel timer: eight pins, each tied to one
// general register (ch0 A,B,C,D; ch1 A,B; ch2 A,B), compare or capture per selector.
// Assumes counter, compare match strobes and clear strobes come from the timer core
// on clk_i; pin inputs are asynchronous and are synchronised here.
`timescale 1ns/1ps
module tio_func_select
    import tio_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Wishbone slave
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  we_i,
    input  wire logic [7:0]            adr_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic [31:0]           dat_i,
    output logic      [31:0]           dat_o,
    output logic                       ack_o,
    // Timer core
    input  wire logic [3*CNT_W-1:0]    counter_i,
    input  wire logic [tio_pkg::NUM_PINS-1:0] match_i,
    input  wire logic [2:0]            clear_i,
    output logic      [tio_pkg::NUM_PINS-1:0] capture_o,
    output logic      [tio_pkg::NUM_PINS*CNT_W-1:0] capture_val_o,
    // Timer pins
    input  wire logic [tio_pkg::NUM_PINS-1:0] pin_i,
    output logic      [tio_pkg::NUM_PINS-1:0] pin_o,
    output logic      [tio_pkg::NUM_PINS-1:0] pin_oe_o
);
    import tio_pkg::*;

    logic [7:0]          io_ctrl_ch0_ab_ff;
    logic [7:0]          io_ctrl_ch0_cd_ff;
    logic [7:0]          io_ctrl_ch1_ff;
    logic [7:0]          io_ctrl_ch2_ff;
    logic [6:0]          ctrl_ff;
    logic                ack_ff;
    logic [31:0]         dat_ff;
    logic [NUM_PINS-1:0] sync1_ff;
    logic [NUM_PINS-1:0] sync2_ff;
    logic [NUM_PINS-1:0] prev_ff;
    logic [NUM_PINS-1:0] level_ff;
    logic [NUM_PINS-1:0] cap_ff;
    logic [NUM_PINS*CNT_W-1:0] cap_val_ff;
    logic [SEL_W-1:0]    func_sel [NUM_PINS];
    logic [NUM_PINS-1:0] pin_blocked;
    logic                bus_req;

    // Pin order: 0 ch0 A, 1 ch0 B, 2 ch0 C, 3 ch0 D, 4 ch1 A, 5 ch1 B, 6 ch2 A, 7 ch2 B
    function automatic int pin_chan(input int p);
        return (p < 4) ? 0 : ((p < 6) ? 1 : 2);
    endfunction

    function automatic logic sel_is_capture(input logic [SEL_W-1:0] s);
        return s[3];
    endfunction

    function automatic logic sel_is_output(input logic [SEL_W-1:0] s);
        return !s[3] && (s[1:0] != 2'b00);
    endfunction

    // Selector slicing per pin
    always_comb begin
        func_sel[0] = io_ctrl_ch0_ab_ff[SEL_LO_B +: SEL_W];
        func_sel[1] = io_ctrl_ch0_ab_ff[SEL_HI_B +: SEL_W];
        func_sel[2] = io_ctrl_ch0_cd_ff[SEL_LO_B +: SEL_W];
        func_sel[3] = io_ctrl_ch0_cd_ff[SEL_HI_B +: SEL_W];
        func_sel[4] = io_ctrl_ch1_ff[SEL_LO_B +: SEL_W];
        func_sel[5] = io_ctrl_ch1_ff[SEL_HI_B +: SEL_W];
        func_sel[6] = io_ctrl_ch2_ff[SEL_LO_B +: SEL_W];
        func_sel[7] = io_ctrl_ch2_ff[SEL_HI_B +: SEL_W];
    end

    // Register C acting as a buffer loses its pin function entirely
    always_comb begin
        pin_blocked    = '0;
        pin_blocked[2] = ctrl_ff[CTRL_BUF_AC];
    end

    assign bus_req = cyc_i && stb_i && !ack_ff;

    // Register writes; byte lane 0 carries the 8-bit registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_ctrl_ch0_ab_ff <= IOCTRL_RST;
            io_ctrl_ch0_cd_ff <= IOCTRL_RST;
            io_ctrl_ch1_ff    <= IOCTRL_RST;
            io_ctrl_ch2_ff    <= IOCTRL_RST;
            ctrl_ff           <= CTRL_RST;
        end else if (bus_req && we_i && sel_i[0]) begin
            unique case (adr_i)
                ADR_CH0_AB: io_ctrl_ch0_ab_ff <= dat_i[7:0];
                ADR_CH0_CD: io_ctrl_ch0_cd_ff <= dat_i[7:0];
                ADR_CH1:    io_ctrl_ch1_ff    <= dat_i[7:0];
                ADR_CH2:    io_ctrl_ch2_ff    <= dat_i[7:0];
                ADR_CTRL:   ctrl_ff           <= dat_i[6:0];
                default: ;
            endcase
        end
    end

    // Single-wait-state answer; unmapped addresses read zero and ignore writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= bus_req;
            if (bus_req && !we_i) begin
                unique case (adr_i)
                    ADR_CH0_AB: dat_ff <= {24'h00_0000, io_ctrl_ch0_ab_ff};
                    ADR_CH0_CD: dat_ff <= {24'h00_0000, io_ctrl_ch0_cd_ff};
                    ADR_CH1:    dat_ff <= {24'h00_0000, io_ctrl_ch1_ff};
                    ADR_CH2:    dat_ff <= {24'h00_0000, io_ctrl_ch2_ff};
                    ADR_CTRL:   dat_ff <= {25'h000_0000, ctrl_ff};
                    ADR_PINS:   dat_ff <= {16'h0000, sync2_ff, level_ff};
                    default:    dat_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign ack_o = ack_ff;
    assign dat_o = dat_ff;

    // Two-stage synchroniser, then edge history from the second stage only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            prev_ff  <= '0;
        end else begin
            sync1_ff <= pin_i;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // Output level per pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_ff <= '0;
        end else begin
            for (int p = 0; p < NUM_PINS; p++) begin
                int  c;
                logic run;
                logic pwm2;
                c    = pin_chan(p);
                run  = ctrl_ff[CTRL_START0 + c];
                pwm2 = ctrl_ff[CTRL_PWM2_0 + c];
                if (sel_is_capture(func_sel[p]) || pin_blocked[p]) begin
                    level_ff[p] <= level_ff[p];
                end else if (!run) begin
                    level_ff[p] <= func_sel[p][2];
                end else if (pwm2 && clear_i[c]) begin
                    level_ff[p] <= func_sel[p][2];
                end else if (match_i[p]) begin
                    unique case (func_sel[p][1:0])
                        2'b01:   level_ff[p] <= 1'b0;
                        2'b10:   level_ff[p] <= 1'b1;
                        2'b11:   level_ff[p] <= !level_ff[p];
                        default: level_ff[p] <= level_ff[p];
                    endcase
                end
            end
        end
    end

    // Drive enable only for live compare codes on the pin's own register
    always_comb begin
        for (int p = 0; p < NUM_PINS; p++) begin
            pin_oe_o[p] = sel_is_output(func_sel[p]) && !pin_blocked[p];
        end
    end

    assign pin_o = level_ff;

    // Input capture; bit 2 is not looked at, which also covers channel 2
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_ff     <= '0;
            cap_val_ff <= '0;
        end else begin
            for (int p = 0; p < NUM_PINS; p++) begin
                logic rise;
                logic fall;
                logic hit;
                rise = sync2_ff[p] && !prev_ff[p];
                fall = !sync2_ff[p] && prev_ff[p];
                hit  = 1'b0;
                if (sel_is_capture(func_sel[p]) && !pin_blocked[p]) begin
                    if (func_sel[p][1]) begin
                        hit = rise || fall;
                    end else if (func_sel[p][0]) begin
                        hit = fall;
                    end else begin
                        hit = rise;
                    end
                end
                cap_ff[p] <= hit;
                if (hit) begin
                    cap_val_ff[p*CNT_W +: CNT_W] <= counter_i[pin_chan(p)*CNT_W +: CNT_W];
                end
            end
        end
    end

    assign capture_o     = cap_ff;
    assign capture_val_o = cap_val_ff;
endmodule

// File: dv/tio_pin_ext.sv
// External pin model for the timer pins.
// Assumes the bench changes ext_lvl_i right after a rising clock edge.
`timescale 1ns/1ps
module tio_pin_ext (
    // Clock and levels
    input  wire logic       clk_i,
    input  wire logic [7:0] ext_lvl_i,
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] oe_i,
    // Resolved pin levels
    output logic      [7:0] pin_o
);
    // Registered so a pin never moves within the edge that moved it
    always_ff @(posedge clk_i) begin
        pin_o <= (oe_i & drv_i) | (~oe_i & ext_lvl_i);
    end
endmodule

// File: dv/tio_func_select_props.sv
// Port checker for the pin function select block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module tio_func_select_props #(
    parameter int CNT_W = 16
) (
    input wire logic                 clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
    input wire logic [7:0]           adr_i, match_i, capture_o, pin_i, pin_o, pin_oe_o,
    input wire logic [31:0]          dat_i, dat_o,
    input wire logic [3*CNT_W-1:0]   counter_i,
    input wire logic [8*CNT_W-1:0]   capture_val_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_follows_req: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
    a_ack_one_cycle: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_ack_needs_req: assert property (
        ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
    a_read_data_hold: assert property (
        $changed(dat_o) && !$past(rst_i) |-> ack_o && !$past(we_i))
        else $error("read data moved");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst_i |=> pin_oe_o == 8'h00 && capture_o == 8'h00 && !ack_o)
        else $error("reset not quiet");
    a_cap_own_edge: assert property (
        capture_o != 8'h00 |-> (capture_o & ~($past(pin_i, 3) ^ $past(pin_i, 4))) == 8'h00)
        else $error("capture without pin edge");
    a_cap_value: assert property (
        capture_o[0] |-> capture_val_o[CNT_W-1:0] == $past(counter_i[CNT_W-1:0]))
        else $error("capture value wrong");
    a_drive_not_cap: assert property ((capture_o & pin_oe_o) == 8'h00)
        else $error("capture on driven pin");
endmodule
bind tio_func_select tio_func_select_props #(.CNT_W(CNT_W)) u_props (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o), .adr_i(adr_i),
    .match_i(match_i), .capture_o(capture_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .dat_i(dat_i), .dat_o(dat_o), .counter_i(counter_i),
    .capture_val_o(capture_val_o));

// File: dv/tb_tio_func_select.sv
// Self-checking bench for the pin function select block.
// Assumes the Wishbone map and one-cycle ack of the package.
`timescale 1ns/1ps
module tb_tio_func_select;
    import tio_pkg::*;
    logic         clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
    logic [7:0]   adr_i = 0, match_i = 0, ext_lvl = 0, capture_o, pin_i, pin_o, pin_oe_o;
    logic [31:0]  dat_i = 0, dat_o, x = 64;
    logic [47:0]  counter_i = 0;
    logic [2:0]   clear_i = 0;
    logic [127:0] capture_val_o;
    logic [15:0]  exp_cap[$];
    logic [32:0]  exp_rd[$];
    int           num_errors = 0, checks_done = 0;
    always #5 clk_i = ~clk_i;
    tio_func_select u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .counter_i(counter_i), .match_i(match_i), .clear_i(clear_i), .capture_o(capture_o),
        .capture_val_o(capture_val_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
    tio_pin_ext u_pins (.clk_i(clk_i), .ext_lvl_i(ext_lvl), .drv_i(pin_o), .oe_i(pin_oe_o),
        .pin_o(pin_i));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [32:0] e);
        int n = 0;
        @(posedge clk_i);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        exp_rd.push_back(e);
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 50);
        if (n >= 50) num_errors++;
        cyc_i <= 0;
        stb_i <= 0;
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk_i) begin
        logic [32:0] e;
        if (!rst_i && ack_o === 1'b1 && exp_rd.size() > 0) begin
            e = exp_rd.pop_front();
            if (e[32]) chk(dat_o, e[31:0], "read data");
        end
        if (!rst_i && capture_o[7:1] !== 7'h0) chk(capture_o, 0, "stray capture");
        if (!rst_i && capture_o[0] === 1'b1)
            chk(capture_val_o[15:0], exp_cap.size() > 0 ? exp_cap.pop_front() : 'x, "capture");
    end
    initial begin
        #100us;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        wb(8'h18, 1, 32'hff, 0);
        for (int a = 0; a <= 8'h18; a += 4) wb(8'(a), 0, 0, {1'b1, 32'h0});
        $display("test reset_values done");
        for (int i = 0; i < 8; i++) begin
            x = xs(x);
            // Output codes only: a capture code here would see the pin fall and capture
            wb(8'(i % 4 * 4), 1, x & 32'h77, 0);
            wb(8'(i % 4 * 4), 0, 0, {1'b1, x & 32'h77});
        end
        $display("test readback done");
        for (int c = 0; c < 8; c++) begin
            wb(ADR_CTRL, 1, 0, 0);
            wb(ADR_CH1, 1, c, 0);
            repeat (2) @(posedge clk_i);
            chk(pin_oe_o[4], c[1:0] != 0, "enable");
            if (c[1:0] != 0) chk(pin_o[4], c[2], "initial level");
            wb(ADR_CTRL, 1, 32'h2, 0);
            @(posedge clk_i) match_i <= 8'h10;
            @(posedge clk_i) match_i <= 8'h00;
            @(posedge clk_i);
            if (c[1:0] != 0)
                chk(pin_o[4], c[1:0] == 1 ? 0 : (c[1:0] == 2 ? 1 : !c[2]), "match level");
        end
        wb(ADR_CH1, 1, 32'h5, 0);
        wb(ADR_CTRL, 1, 32'h22, 0);
        @(posedge clk_i) match_i <= 8'h10;
        @(posedge clk_i) match_i <= 8'h00;
        @(posedge clk_i);
        chk(pin_o[4], 0, "pwm2 match");
        clear_i <= 3'h2;
        @(posedge clk_i) clear_i <= 3'h0;
        @(posedge clk_i);
        chk(pin_o[4], 1, "pwm2 clear level");
        $display("test compare done");
        wb(ADR_CH0_CD, 1, 32'h3, 0);
        wb(ADR_CTRL, 1, 32'h9, 0);
        @(posedge clk_i) match_i <= 8'h04;
        @(posedge clk_i) match_i <= 8'h00;
        chk(pin_oe_o[2], 0, "buffer blocks pin");
        wb(ADR_CTRL, 1, 32'h1, 0);
        chk(pin_oe_o[2], 1, "selector back");
        $display("test buffer done");
        for (int c = 8; c < 11; c++) begin
            x = xs(x);
            counter_i <= {32'h0, x[15:0]};
            wb(ADR_CH0_AB, 1, c, 0);
            for (int k = 0; k < 4; k++) begin
                @(posedge clk_i) ext_lvl[0] <= !ext_lvl[0];
                if (c == 10 || ext_lvl[0] == (c == 9)) exp_cap.push_back(x[15:0]);
                repeat (8) @(posedge clk_i);
            end
        end
        chk(exp_cap.size(), 0, "missing capture");
        $display("test capture done");
        end_of_test();
    end
endmodule
